//--- bf_pkg.sv
package bf_pkg;
    // widths of the datapath
    localparam int FIELD_W = 32;
    localparam int OPND_W = 40;
    localparam int WID_W = 6;
    localparam int OFS_IMM_W = 5;
    localparam int WID_IMM_W = 5;
    localparam int MEM_PAD = 2 * FIELD_W - OPND_W;
    localparam int REG_BIT_HI = 4;
    localparam int BYTE_BIT_HI = 2;
    localparam int BYTE_SHIFT = 3;

    // extension word layout
    localparam int EXT_ZERO_BIT = 15;
    localparam int EXT_DEST_HI = 14;
    localparam int EXT_DEST_LO = 12;
    localparam int EXT_OFS_FLAG = 11;
    localparam int EXT_OFS_HI = 10;
    localparam int EXT_OFS_LO = 6;
    localparam int EXT_OREG_HI = 8;
    localparam int EXT_OREG_LO = 6;
    localparam int EXT_WID_FLAG = 5;
    localparam int EXT_WID_HI = 4;
    localparam int EXT_WID_LO = 0;
    localparam int EXT_WREG_HI = 2;
    localparam int EXT_WREG_LO = 0;

    // operation word layout
    localparam int OP_CLASS_HI = 15;
    localparam int OP_CLASS_LO = 6;
    localparam int OP_MODE_HI = 5;
    localparam int OP_MODE_LO = 3;
    localparam int OP_EREG_HI = 2;
    localparam int OP_EREG_LO = 0;

    // upper ten bits of the operation word per operation
    localparam logic [9:0] CLASS_EXTU = 10'h3a7;
    localparam logic [9:0] CLASS_EXTS = 10'h3af;
    localparam logic [9:0] CLASS_FFO = 10'h3b7;

    // addressing mode codes
    localparam logic [2:0] MODE_DREG = 3'h0;
    localparam logic [2:0] MODE_AREG = 3'h1;
    localparam logic [2:0] MODE_AIND = 3'h2;
    localparam logic [2:0] MODE_PINC = 3'h3;
    localparam logic [2:0] MODE_PDEC = 3'h4;
    localparam logic [2:0] MODE_DISP = 3'h5;
    localparam logic [2:0] MODE_INDEX = 3'h6;
    localparam logic [2:0] MODE_EXT = 3'h7;
    localparam logic [2:0] XREG_ABS_W = 3'h0;
    localparam logic [2:0] XREG_ABS_L = 3'h1;
    localparam logic [2:0] XREG_PC_DISP = 3'h2;
    localparam logic [2:0] XREG_PC_INDEX = 3'h3;

    // width code zero stands for a full register
    localparam logic [WID_W-1:0] WIDTH_FULL = 6'h20;

    typedef enum logic [2:0] {
        KIND_DREG = 3'b000,
        KIND_AIND = 3'b001,
        KIND_DISP = 3'b010,
        KIND_INDEX = 3'b011,
        KIND_ABS_W = 3'b100,
        KIND_ABS_L = 3'b101,
        KIND_PC_DISP = 3'b110,
        KIND_PC_INDEX = 3'b111
    } opnd_kind_e;

    typedef enum logic [1:0] {
        OP_EXTU = 2'b00,
        OP_EXTS = 2'b01,
        OP_FFO = 2'b10
    } bf_op_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_REGS = 2'b01,
        ST_OPND = 2'b10,
        ST_EXEC = 2'b11
    } bf_state_e;
endpackage

//--- field_if.sv
`timescale 1ns/1ps
`default_nettype none
interface field_if;
    import bf_pkg::*;
    logic [OPND_W-1:0] src;
    logic reg_direct;
    logic [FIELD_W-1:0] offset;
    logic [WID_W-1:0] width;
    logic [FIELD_W-1:0] field_u;
    logic [FIELD_W-1:0] field_s;
    logic [FIELD_W-1:0] ffo_pos;
    logic msb;
    logic zero;
    modport requester (
        output src, reg_direct, offset, width,
        input field_u, field_s, ffo_pos, msb, zero
    );
    modport engine (
        input src, reg_direct, offset, width,
        output field_u, field_s, ffo_pos, msb, zero
    );
endinterface
`default_nettype wire

//--- bf_field_engine.sv
`timescale 1ns/1ps
`default_nettype none
module bf_field_engine (
    field_if.engine f
);
    import bf_pkg::*;

    logic [2*FIELD_W-1:0] wide;
    logic [2*FIELD_W-1:0] shifted;
    logic [FIELD_W-1:0] aligned;
    logic [FIELD_W-1:0] keep;
    logic [FIELD_W-1:0] masked;
    logic [REG_BIT_HI:0] start;
    logic [REG_BIT_HI:0] sh;
    logic [WID_W-1:0] lz;
    logic found;

    // bring the field's first bit to the top, then trim below its last bit
    always_comb begin
        // a register wraps round on itself; memory runs on into the next bytes
        if (f.reg_direct) begin
            wide = {f.src[FIELD_W-1:0], f.src[FIELD_W-1:0]};
            start = f.offset[REG_BIT_HI:0];
        end else begin
            wide = {f.src, {MEM_PAD{1'b0}}};
            start = {2'h0, f.offset[BYTE_BIT_HI:0]};
        end
        shifted = wide << start;
        aligned = shifted[2*FIELD_W-1:FIELD_W];
        sh = 5'(WIDTH_FULL - f.width);
        keep = {FIELD_W{1'b1}} << sh;
        masked = aligned & keep;
        f.field_u = masked >> sh;
        f.field_s = 32'($signed(masked) >>> sh);
        f.msb = aligned[FIELD_W-1];
        f.zero = (masked == {FIELD_W{1'b0}});
        // scan from the top; an empty field leaves the width as the count
        lz = f.width;
        found = 1'b0;
        for (int i = 0; i < FIELD_W; i++) begin
            if (!found && masked[FIELD_W-1-i]) begin
                lz = 6'(i);
                found = 1'b1;
            end
        end
        f.ffo_pos = f.offset + {{(FIELD_W-WID_W){1'b0}}, lz};
    end
endmodule
`default_nettype wire

//--- bf_extract_scan.sv
// Function
// - offset flag clear: offset is the five-bit immediate, 0 to 31.
// - offset flag set: extension bits 8..6 name the offset data register.
// - a register offset is a full signed 32-bit value.
// - width flag set: extension bits 2..0 name the width data register.
// - immediate width codes 1..31 mean that many bits, zero means 32.
// - register width taken modulo 32, zero meaning 32 bits.
// - offset picks the first field bit, width the count of bits.
// - signed extract copies the field's top bit up to 32 bits.
// - unsigned extract fills the upper bits with zeros.
// - N is field top bit, Z all-zero field, V and C cleared, X kept.
// - scan result is offset plus position of the first set bit.
// - scan of an empty field returns offset plus width.
// - legal base modes are 000, 010, 101, 110 and 111; others refused.
// - mode 111 register codes 000..011 are the absolute and pc forms.
// - extension bits 14..12 choose the destination data register.
`timescale 1ns/1ps
`default_nettype none
module bf_extract_scan (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic START,
    input wire logic [15:0] OPWORD,
    input wire logic [15:0] EXTWORD,
    input wire logic REG_RD_ACK,
    input wire logic [bf_pkg::FIELD_W-1:0] OFS_REG_DATA,
    input wire logic [bf_pkg::FIELD_W-1:0] WID_REG_DATA,
    input wire logic OPND_ACK,
    input wire logic [bf_pkg::OPND_W-1:0] OPND_DATA,
    output logic BUSY,
    output logic ILLEGAL,
    output logic DONE,
    output logic REG_RD_REQ,
    output logic [2:0] OFS_REG_SEL,
    output logic [2:0] WID_REG_SEL,
    output logic OPND_REQ,
    output var bf_pkg::opnd_kind_e OPND_KIND,
    output logic [2:0] OPND_EREG,
    output logic [bf_pkg::FIELD_W-1:0] OPND_BYTE_OFS,
    output logic RESULT_WE,
    output logic [2:0] DEST_SEL,
    output logic [bf_pkg::FIELD_W-1:0] RESULT,
    output logic CC_WE,
    output logic CC_N,
    output logic CC_Z,
    output logic CC_V,
    output logic CC_C
);
    import bf_pkg::*;

    typedef struct packed {
        bf_state_e state;
        bf_op_e op;
        logic [15:0] ext;
        logic [FIELD_W-1:0] offset;
        logic [WID_W-1:0] width;
        logic [OPND_W-1:0] src;
        logic busy;
        logic illegal;
        logic done;
        logic reg_rd_req;
        logic [2:0] ofs_sel;
        logic [2:0] wid_sel;
        logic opnd_req;
        opnd_kind_e kind;
        logic [2:0] ereg;
        logic [FIELD_W-1:0] byte_ofs;
        logic result_we;
        logic [2:0] dest_sel;
        logic [FIELD_W-1:0] result;
        logic cc_we;
        logic cc_n;
        logic cc_z;
        logic cc_v;
        logic cc_c;
    } bf_regs_s;

    bf_regs_s r;
    bf_regs_s next_r;
    field_if fi ();

    logic [9:0] op_class;
    logic [2:0] ea_mode;
    logic [2:0] ea_reg;
    logic class_ok;
    logic mode_ok;
    bf_op_e dec_op;
    opnd_kind_e dec_kind;

    // immediate offset is unsigned; a register offset keeps all 32 signed bits
    function automatic logic [FIELD_W-1:0] pick_offset(input logic [15:0] ext,
                                                       input logic [FIELD_W-1:0] data);
        if (ext[EXT_OFS_FLAG]) begin
            pick_offset = data;
        end else begin
            pick_offset = {{(FIELD_W-OFS_IMM_W){1'b0}}, ext[EXT_OFS_HI:EXT_OFS_LO]};
        end
    endfunction

    // only the low five bits of a width count, so wide values wrap
    function automatic logic [WID_W-1:0] pick_width(input logic [15:0] ext,
                                                    input logic [FIELD_W-1:0] data);
        logic [WID_IMM_W-1:0] code;
        if (ext[EXT_WID_FLAG]) begin
            code = data[WID_IMM_W-1:0];
        end else begin
            code = ext[EXT_WID_HI:EXT_WID_LO];
        end
        pick_width = (code == {WID_IMM_W{1'b0}}) ? WIDTH_FULL : {1'b0, code};
    endfunction

    // opcode and addressing-mode decode of the word on the request port
    always_comb begin
        op_class = OPWORD[OP_CLASS_HI:OP_CLASS_LO];
        ea_mode = OPWORD[OP_MODE_HI:OP_MODE_LO];
        ea_reg = OPWORD[OP_EREG_HI:OP_EREG_LO];
        class_ok = 1'b1;
        dec_op = OP_EXTU;
        if (op_class == CLASS_EXTS) begin
            dec_op = OP_EXTS;
        end else if (op_class == CLASS_FFO) begin
            dec_op = OP_FFO;
        end else if (op_class != CLASS_EXTU) begin
            class_ok = 1'b0;
        end
        mode_ok = 1'b1;
        dec_kind = KIND_DREG;
        unique case (ea_mode)
            MODE_DREG: dec_kind = KIND_DREG;
            MODE_AIND: dec_kind = KIND_AIND;
            MODE_DISP: dec_kind = KIND_DISP;
            MODE_INDEX: dec_kind = KIND_INDEX;
            MODE_EXT: begin
                if (ea_reg == XREG_ABS_W) begin
                    dec_kind = KIND_ABS_W;
                end else if (ea_reg == XREG_ABS_L) begin
                    dec_kind = KIND_ABS_L;
                end else if (ea_reg == XREG_PC_DISP) begin
                    dec_kind = KIND_PC_DISP;
                end else if (ea_reg == XREG_PC_INDEX) begin
                    dec_kind = KIND_PC_INDEX;
                end else begin
                    mode_ok = 1'b0;
                end
            end
            MODE_AREG, MODE_PINC, MODE_PDEC: mode_ok = 1'b0;
        endcase
    end

    // the engine works only from registered state, so its inputs are stable
    assign fi.src = r.src;
    assign fi.reg_direct = (r.kind == KIND_DREG);
    assign fi.offset = r.offset;
    assign fi.width = r.width;

    bf_field_engine u_engine (
        .f(fi)
    );

    // sequencer: decode, optional register reads, operand fetch, execute
    always_comb begin
        next_r = r;
        next_r.illegal = 1'b0;
        next_r.done = 1'b0;
        next_r.result_we = 1'b0;
        next_r.cc_we = 1'b0;
        unique case (r.state)
            ST_IDLE: begin
                if (START) begin
                    if (!class_ok || !mode_ok) begin
                        next_r.illegal = 1'b1;
                    end else begin
                        next_r.busy = 1'b1;
                        next_r.op = dec_op;
                        next_r.kind = dec_kind;
                        next_r.ereg = ea_reg;
                        next_r.ext = EXTWORD;
                        next_r.dest_sel = EXTWORD[EXT_DEST_HI:EXT_DEST_LO];
                        next_r.ofs_sel = EXTWORD[EXT_OREG_HI:EXT_OREG_LO];
                        next_r.wid_sel = EXTWORD[EXT_WREG_HI:EXT_WREG_LO];
                        if (EXTWORD[EXT_OFS_FLAG] || EXTWORD[EXT_WID_FLAG]) begin
                            next_r.reg_rd_req = 1'b1;
                            next_r.state = ST_REGS;
                        end else begin
                            // immediates only: skip the register read
                            next_r.offset = pick_offset(EXTWORD, {FIELD_W{1'b0}});
                            next_r.width = pick_width(EXTWORD, {FIELD_W{1'b0}});
                            next_r.byte_ofs = next_r.offset >> BYTE_SHIFT;
                            next_r.opnd_req = 1'b1;
                            next_r.state = ST_OPND;
                        end
                    end
                end
            end
            ST_REGS: begin
                if (REG_RD_ACK) begin
                    next_r.reg_rd_req = 1'b0;
                    next_r.offset = pick_offset(r.ext, OFS_REG_DATA);
                    next_r.width = pick_width(r.ext, WID_REG_DATA);
                    // negative offsets reach bytes below the base address
                    next_r.byte_ofs = 32'($signed(next_r.offset) >>> BYTE_SHIFT);
                    next_r.opnd_req = 1'b1;
                    next_r.state = ST_OPND;
                end
            end
            ST_OPND: begin
                if (OPND_ACK) begin
                    next_r.opnd_req = 1'b0;
                    next_r.src = OPND_DATA;
                    next_r.state = ST_EXEC;
                end
            end
            ST_EXEC: begin
                unique case (r.op)
                    OP_EXTS: next_r.result = fi.field_s;
                    OP_EXTU: next_r.result = fi.field_u;
                    OP_FFO: next_r.result = fi.ffo_pos;
                    default: next_r.result = fi.field_u;
                endcase
                // no extend flag port: the extend bit is never touched
                next_r.cc_n = fi.msb;
                next_r.cc_z = fi.zero;
                next_r.cc_v = 1'b0;
                next_r.cc_c = 1'b0;
                next_r.cc_we = 1'b1;
                next_r.result_we = 1'b1;
                next_r.done = 1'b1;
                next_r.busy = 1'b0;
                next_r.state = ST_IDLE;
            end
        endcase
    end

    // synchronous reset clears the whole state word at once
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // every output straight from the state register
    assign BUSY = r.busy;
    assign ILLEGAL = r.illegal;
    assign DONE = r.done;
    assign REG_RD_REQ = r.reg_rd_req;
    assign OFS_REG_SEL = r.ofs_sel;
    assign WID_REG_SEL = r.wid_sel;
    assign OPND_REQ = r.opnd_req;
    assign OPND_KIND = r.kind;
    assign OPND_EREG = r.ereg;
    assign OPND_BYTE_OFS = r.byte_ofs;
    assign RESULT_WE = r.result_we;
    assign DEST_SEL = r.dest_sel;
    assign RESULT = r.result;
    assign CC_WE = r.cc_we;
    assign CC_N = r.cc_n;
    assign CC_Z = r.cc_z;
    assign CC_V = r.cc_v;
    assign CC_C = r.cc_c;

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);

    a_illegal_mode: assert property (
        r.state == ST_IDLE && START && OPWORD[OP_MODE_HI:OP_MODE_LO] == MODE_AREG
        |=> ILLEGAL && !BUSY && r.state == ST_IDLE)
        else $error("address register direct base not refused");

    a_pc_disp_kind: assert property (
        r.state == ST_IDLE && START && class_ok
        && OPWORD[OP_MODE_HI:OP_MODE_LO] == MODE_EXT
        && OPWORD[OP_EREG_HI:OP_EREG_LO] == XREG_PC_DISP
        |=> OPND_KIND == KIND_PC_DISP && BUSY)
        else $error("pc displacement form not decoded");

    a_imm_offset: assert property (
        r.state == ST_OPND && !r.ext[EXT_OFS_FLAG]
        |-> r.offset == {{(FIELD_W-OFS_IMM_W){1'b0}}, r.ext[EXT_OFS_HI:EXT_OFS_LO]})
        else $error("immediate offset taken wrongly");

    a_width_range: assert property (
        r.state == ST_OPND |-> r.width != {WID_W{1'b0}} && r.width <= WIDTH_FULL)
        else $error("field width outside one to thirty-two");

    a_reg_width_mod: assert property (
        r.state == ST_REGS && REG_RD_ACK && r.ext[EXT_WID_FLAG]
        && WID_REG_DATA[WID_IMM_W-1:0] == {WID_IMM_W{1'b0}}
        |=> r.width == WIDTH_FULL && OPND_REQ)
        else $error("register width zero not read as full");

    a_reg_read_seq: assert property (
        REG_RD_REQ && REG_RD_ACK |=> !REG_RD_REQ && OPND_REQ ##1 OPND_REQ || OPND_ACK)
        else $error("register read not followed by operand fetch");

    a_exec_finish: assert property (
        r.state == ST_OPND && OPND_ACK |=> r.state == ST_EXEC ##1 DONE && CC_WE && !BUSY)
        else $error("execute did not finish two cycles after operand");

    a_cc_vc_clear: assert property (
        CC_WE |-> !CC_V && !CC_C && !(CC_Z && CC_N))
        else $error("overflow or carry left set, or N with Z");

    a_signed_top: assert property (
        RESULT_WE && r.op == OP_EXTS |-> RESULT[FIELD_W-1] == CC_N)
        else $error("signed extract not sign extended");

    a_unsigned_top: assert property (
        RESULT_WE && r.op == OP_EXTU && r.width != WIDTH_FULL |-> !RESULT[FIELD_W-1])
        else $error("unsigned extract upper bits not zero");

    a_scan_empty: assert property (
        RESULT_WE && r.op == OP_FFO && CC_Z
        |-> RESULT == r.offset + {{(FIELD_W-WID_W){1'b0}}, r.width})
        else $error("empty field scan not offset plus width");

    a_scan_bound: assert property (
        RESULT_WE && r.op == OP_FFO && !CC_Z
        |-> (RESULT - r.offset) < {{(FIELD_W-WID_W){1'b0}}, r.width})
        else $error("scan position outside the field");

    a_dest_sel: assert property (
        RESULT_WE |-> DEST_SEL == r.ext[EXT_DEST_HI:EXT_DEST_LO] && $stable(DEST_SEL))
        else $error("destination register select wrong");
endmodule
`default_nettype wire

//--- bf_operand_partner.sv
`timescale 1ns/1ps
`default_nettype none
// fetch and operand side of the processor, answering after a set wait
module bf_operand_partner (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [3:0] wait_cycles,
    input wire logic reg_rd_req,
    input wire logic [2:0] ofs_reg_sel,
    input wire logic [2:0] wid_reg_sel,
    input wire logic opnd_req,
    input wire logic [2:0] opnd_kind,
    input wire logic [2:0] opnd_ereg,
    input wire logic [bf_pkg::FIELD_W-1:0] opnd_byte_ofs,
    output logic reg_rd_ack,
    output logic [bf_pkg::FIELD_W-1:0] ofs_reg_data,
    output logic [bf_pkg::FIELD_W-1:0] wid_reg_data,
    output logic opnd_ack,
    output logic [bf_pkg::OPND_W-1:0] opnd_data
);
    import bf_pkg::*;
    logic [31:0] dregs [8];
    logic [3:0] reg_wait;
    logic [3:0] opnd_wait;

    // memory is a fixed byte pattern, base address taken as zero
    function automatic logic [7:0] mem_byte(input logic [31:0] addr);
        return (addr[7:0] * 8'h25) ^ 8'h3c;
    endfunction

    // data toggles outside the ack cycle so stale values never match
    always_ff @(posedge clock) begin
        ofs_reg_data <= rst_n ? ~ofs_reg_data : 32'h5ac3_5ac3;
        wid_reg_data <= rst_n ? ~wid_reg_data : 32'h3c5a_a5c3;
        if (!rst_n || !reg_rd_req || reg_rd_ack) begin
            reg_rd_ack <= 1'b0;
            reg_wait <= 4'h0;
        end else if (reg_wait == wait_cycles) begin
            reg_rd_ack <= 1'b1;
            ofs_reg_data <= dregs[ofs_reg_sel];
            wid_reg_data <= dregs[wid_reg_sel];
        end else begin
            reg_wait <= reg_wait + 4'h1;
        end
    end

    // five bytes from the byte offset, or the register for direct mode
    always_ff @(posedge clock) begin
        opnd_data <= rst_n ? ~opnd_data : 40'h5a_c35a_c35a;
        if (!rst_n || !opnd_req || opnd_ack) begin
            opnd_ack <= 1'b0;
            opnd_wait <= 4'h0;
        end else if (opnd_wait == wait_cycles) begin
            opnd_ack <= 1'b1;
            if (opnd_kind == 3'h0) begin
                opnd_data <= {8'ha5, dregs[opnd_ereg]};
            end else begin
                opnd_data <= {mem_byte(opnd_byte_ofs), mem_byte(opnd_byte_ofs + 32'd1),
                    mem_byte(opnd_byte_ofs + 32'd2), mem_byte(opnd_byte_ofs + 32'd3),
                    mem_byte(opnd_byte_ofs + 32'd4)};
            end
        end else begin
            opnd_wait <= opnd_wait + 4'h1;
        end
    end
endmodule
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import bf_pkg::*;
    typedef struct {logic [1:0] op; logic [2:0] md; logic [2:0] er; logic [15:0] ext;
        logic bad; logic [2:0] kind;} row_s;
    logic CLOCK = 1'b0;
    logic RST_N = 1'b0;
    logic START, REG_RD_ACK, OPND_ACK, BUSY, ILLEGAL, DONE, REG_RD_REQ, OPND_REQ;
    logic RESULT_WE, CC_WE, CC_N, CC_Z, CC_V, CC_C;
    logic [15:0] OPWORD, EXTWORD;
    logic [31:0] OFS_REG_DATA, WID_REG_DATA, OPND_BYTE_OFS, RESULT;
    logic [39:0] OPND_DATA;
    logic [2:0] OFS_REG_SEL, WID_REG_SEL, OPND_EREG, DEST_SEL;
    opnd_kind_e OPND_KIND;
    logic [3:0] wait_cycles;
    logic got_done, got_ill, got_we;
    int miscompares = 0;
    int checked = 0;
    row_s rows [19];

    always #20 CLOCK = ~CLOCK;

    bf_extract_scan dut_u (.CLOCK(CLOCK), .RST_N(RST_N), .START(START), .OPWORD(OPWORD),
        .EXTWORD(EXTWORD), .REG_RD_ACK(REG_RD_ACK), .OFS_REG_DATA(OFS_REG_DATA),
        .WID_REG_DATA(WID_REG_DATA), .OPND_ACK(OPND_ACK), .OPND_DATA(OPND_DATA), .BUSY(BUSY),
        .ILLEGAL(ILLEGAL), .DONE(DONE), .REG_RD_REQ(REG_RD_REQ), .OFS_REG_SEL(OFS_REG_SEL),
        .WID_REG_SEL(WID_REG_SEL), .OPND_REQ(OPND_REQ), .OPND_KIND(OPND_KIND),
        .OPND_EREG(OPND_EREG), .OPND_BYTE_OFS(OPND_BYTE_OFS), .RESULT_WE(RESULT_WE),
        .DEST_SEL(DEST_SEL), .RESULT(RESULT), .CC_WE(CC_WE), .CC_N(CC_N), .CC_Z(CC_Z),
        .CC_V(CC_V), .CC_C(CC_C));

    bf_operand_partner partner_u (.clock(CLOCK), .rst_n(RST_N), .wait_cycles(wait_cycles),
        .reg_rd_req(REG_RD_REQ), .ofs_reg_sel(OFS_REG_SEL), .wid_reg_sel(WID_REG_SEL),
        .opnd_req(OPND_REQ), .opnd_kind(OPND_KIND), .opnd_ereg(OPND_EREG),
        .opnd_byte_ofs(OPND_BYTE_OFS), .reg_rd_ack(REG_RD_ACK), .ofs_reg_data(OFS_REG_DATA),
        .wid_reg_data(WID_REG_DATA), .opnd_ack(OPND_ACK), .opnd_data(OPND_DATA));

    task automatic check(input logic [39:0] seen, input logic [39:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic stop_test();
        if (miscompares == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // reference: walk the field bit by bit from its first bit
    function automatic void model(input logic [1:0] op, input logic [2:0] md,
        input logic [2:0] er, input logic [15:0] ext, output logic [31:0] res,
        output logic n, output logic z);
        logic [31:0] ofs, g, f;
        logic [7:0] byt;
        logic b, found;
        int w, k;
        ofs = ext[11] ? partner_u.dregs[ext[8:6]] : {27'h0, ext[10:6]};
        w = ext[5] ? partner_u.dregs[ext[2:0]][4:0] : ext[4:0];
        if (w == 0) w = 32;
        f = 32'h0;
        found = 1'b0;
        res = ofs + w;
        for (k = 0; k < w; k++) begin
            g = ofs + k;
            byt = partner_u.mem_byte({{3{g[31]}}, g[31:3]});
            b = (md == MODE_DREG) ? partner_u.dregs[er][31 - g[4:0]] : byt[7 - g[2:0]];
            if (k == 0) n = b;
            if (b && !found && op == OP_FFO) begin
                res = g;
                found = 1'b1;
            end
            f = {f[30:0], b};
        end
        z = (f == 32'h0);
        if (op == OP_EXTU) res = f;
        if (op == OP_EXTS) res = (w == 32) ? f : (f | ({32{n}} << w));
    endfunction

    function automatic logic [9:0] cls_of(input logic [1:0] op);
        case (op)
            OP_EXTU: return CLASS_EXTU;
            OP_EXTS: return CLASS_EXTS;
            OP_FFO: return CLASS_FFO;
            default: return 10'h3a6;
        endcase
    endfunction

    task automatic start_op(input logic [9:0] c, input logic [2:0] m, input logic [2:0] r,
        input logic [15:0] e);
        START = 1'b1;
        OPWORD = {c, m, r};
        EXTWORD = e;
        @(posedge CLOCK);
        #1;
        START = 1'b0;
    endtask

    // bounded wait; the first look is in the cycle an illegal pulse shows
    task automatic wait_end();
        int k;
        for (k = 0; k < 60; k++) begin
            got_done = (DONE === 1'b1);
            got_ill = (ILLEGAL === 1'b1);
            got_we = (RESULT_WE === 1'b1) && (CC_WE === 1'b1);
            if (got_done || got_ill) break;
            @(posedge CLOCK);
            #1;
        end
    endtask

    task automatic do_row(input int i);
        logic [31:0] res;
        logic n, z;
        model(rows[i].op, rows[i].md, rows[i].er, rows[i].ext, res, n, z);
        start_op(cls_of(rows[i].op), rows[i].md, rows[i].er, rows[i].ext);
        wait_end();
        if (rows[i].bad) begin
            check(got_ill, 1'b1, "illegal pulse");
            check(got_done, 1'b0, "done on illegal");
            @(posedge CLOCK);
            #1;
        end else begin
            check(got_done, 1'b1, "done pulse");
            check(got_we, 1'b1, "write strobes");
            check(BUSY, 1'b0, "busy at done");
            if (rows[i].op == OP_EXTS) check(RESULT, res, "signed field");
            else if (rows[i].op == OP_EXTU) check(RESULT, res, "unsigned field");
            else check(RESULT, res, "scan result");
            check(CC_N, n, "n flag");
            check(CC_Z, z, "z flag");
            check({CC_V, CC_C}, 2'b00, "v and c");
            check(DEST_SEL, rows[i].ext[14:12], "destination");
            check(OPND_KIND, rows[i].kind, "operand kind");
        end
    endtask

    // watchdog: about twenty times the expected run length
    initial begin
        repeat (5000) @(posedge CLOCK);
        miscompares++;
        stop_test();
    end

    initial begin
        START = 1'b0;
        OPWORD = 16'h0;
        EXTWORD = 16'h0;
        wait_cycles = 4'h0;
        partner_u.dregs = '{32'hf0f0_1234, 32'd45, 32'h27, 32'h0, 32'hffff_fff3, 32'h40,
            32'h25, 32'h8123_4567};
        rows = '{
            '{OP_EXTU, 3'h0, 3'h0, 16'h1108, 1'b0, 3'h0},
            '{OP_EXTS, 3'h0, 3'h0, 16'h2004, 1'b0, 3'h0},
            '{OP_EXTS, 3'h0, 3'h0, 16'h3708, 1'b0, 3'h0},
            '{OP_FFO, 3'h0, 3'h3, 16'h40c0, 1'b0, 3'h0},
            '{OP_FFO, 3'h0, 3'h0, 16'h510c, 1'b0, 3'h0},
            '{OP_EXTU, 3'h2, 3'h1, 16'h6926, 1'b0, 3'h1},
            '{OP_EXTS, 3'h5, 3'h2, 16'h77c0, 1'b0, 3'h2},
            '{OP_FFO, 3'h6, 3'h3, 16'h0925, 1'b0, 3'h3},
            '{OP_EXTU, 3'h7, 3'h0, 16'h1250, 1'b0, 3'h4},
            '{OP_EXTS, 3'h7, 3'h1, 16'h2314, 1'b0, 3'h5},
            '{OP_FFO, 3'h7, 3'h2, 16'h31c1, 1'b0, 3'h6},
            '{OP_EXTU, 3'h7, 3'h3, 16'h485f, 1'b0, 3'h7},
            '{OP_EXTS, 3'h0, 3'h7, 16'h5022, 1'b0, 3'h0},
            '{OP_EXTU, 3'h1, 3'h0, 16'h1108, 1'b1, 3'h0},
            '{OP_EXTS, 3'h3, 3'h0, 16'h1108, 1'b1, 3'h0},
            '{OP_FFO, 3'h4, 3'h0, 16'h1108, 1'b1, 3'h0},
            '{OP_EXTU, 3'h7, 3'h4, 16'h1108, 1'b1, 3'h0},
            '{OP_EXTS, 3'h7, 3'h7, 16'h1108, 1'b1, 3'h0},
            '{2'h3, 3'h0, 3'h0, 16'h1108, 1'b1, 3'h0}};
        repeat (10) @(posedge CLOCK);
        #1;
        check({BUSY, ILLEGAL, DONE}, 3'h0, "reset idle");
        check({REG_RD_REQ, OPND_REQ, RESULT_WE, CC_WE}, 4'h0, "reset strobes");
        check(RESULT, 32'h0, "reset result");
        RST_N = 1'b1;
        // rows back to back, prompt answers first and then slow ones
        for (int p = 0; p < 2; p++) begin
            wait_cycles = 4'(p * 3);
            for (int i = 0; i < 19; i++) do_row(i);
        end
        // a second start while busy must leave the first operation alone
        start_op(CLASS_EXTU, MODE_DREG, 3'h0, 16'h1108);
        @(posedge CLOCK);
        #1;
        START = 1'b1;
        EXTWORD = 16'h6108;
        @(posedge CLOCK);
        #1;
        START = 1'b0;
        check(BUSY, 1'b1, "busy during fetch");
        wait_end();
        check(DEST_SEL, 3'h1, "destination while busy");
        check(RESULT, 32'h0000_000f, "field while busy");
        got_done = 1'b0;
        repeat (8) begin
            @(posedge CLOCK);
            #1;
            if (DONE === 1'b1) got_done = 1'b1;
        end
        check(got_done, 1'b0, "extra completion");
        // reset in mid operation drops every request and strobe
        start_op(CLASS_EXTU, MODE_AIND, 3'h1, 16'h6926);
        RST_N = 1'b0;
        @(posedge CLOCK);
        #1;
        check({BUSY, DONE, REG_RD_REQ, OPND_REQ, RESULT_WE, CC_WE}, 6'h0, "mid reset");
        RST_N = 1'b1;
        do_row(5);
        do_row(0);
        stop_test();
    end
endmodule
`default_nettype wire
